// [pkg/sdio_pkg.sv]
// Package for the script-driven general purpose line port.
// Assumes one clock domain; shared by the port logic and its bench.
`default_nettype none
package sdio_pkg;
  localparam int LINE_W = 8;
  localparam int PORT_N = 2;
  localparam int IDX_W = 4;
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] OUT_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef enum logic [2:0] {
    SDIO_CFG_LINE,
    SDIO_CFG_PORT,
    SDIO_RD_LINE,
    SDIO_RD_PORT,
    SDIO_WR_LINE,
    SDIO_WR_PORT
  } sdio_op_e;

  typedef enum {SDIO_IDLE, SDIO_EXEC} sdio_state_e;

  // One script command as it arrives from the sequencer
  typedef struct packed {
    sdio_op_e op;
    logic [0:0] port;
    logic [2:0] line;
    logic [7:0] value;
  } sdio_cmd_s;
endpackage
`default_nettype wire

// [logic/sdio_port.sv]
// Script-command general purpose line port with per-command result store.
// Assumes the sequencer holds cmdValid until cmdReady and pins are synchronous.
// Contract
// - Port read samples all eight lines together and returns one byte.
// - Single-line write changes only the selected line of the selected port.
// - Single-line write of 1 drives the selected line high.
// - Single-line write of 0 drives the selected line low.
// - Port write takes one eight-bit value covering every line.
// - Port write updates only output lines; input lines keep their role.
// - In a two-port build each command acts on the port chosen by its port number; a single-port build uses port 0.
// - Each read result is stored under its script position index.
// - Direction byte bit 1 makes a line output, 0 makes it input.
// - Single-line read returns 0 for low and 1 for high.
`default_nettype none
module sdio_port
  import sdio_pkg::*;
#(
  parameter int PORTS = PORT_N,
  parameter int SCRIPT_DEPTH = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic cmdValid,
  input wire sdio_cmd_s cmd,
  input wire logic [IDX_W-1:0] cmdIndex,
  output logic cmdReady,
  input wire logic [IDX_W-1:0] fetchIndex,
  output logic [7:0] fetchData,
  input wire logic [PORTS*LINE_W-1:0] lineIn,
  output logic [PORTS*LINE_W-1:0] lineOut,
  output logic [PORTS*LINE_W-1:0] lineOe
);
  // Elaboration checks: the port field is one bit wide and a port is one byte
  initial begin
    if (LINE_W != 8) $error("LINE_W must be 8");
    if (PORTS < 1 || PORTS > 2) $error("PORTS must be 1 or 2");
    if (SCRIPT_DEPTH != (1 << IDX_W)) $error("SCRIPT_DEPTH must match index width");
  end

  typedef struct packed {
    sdio_state_e st;
    logic ready;
    logic [PORTS-1:0][7:0] dir;
    logic [PORTS-1:0][7:0] out;
    logic [7:0] fetch;
  } sdio_state_s;

  sdio_state_s s_reg, s_next;
  logic [7:0] results [SCRIPT_DEPTH];
  logic resWe;
  logic [7:0] resData;
  sdio_cmd_s c_reg;
  logic [IDX_W-1:0] idx_reg;

  // Port select clipped so a single-port build never indexes past port 0
  function automatic int selPort(input logic [0:0] p);
    return (PORTS == 1) ? 0 : int'(p);
  endfunction

  // Next-state logic: one command per two cycles, accepted only in idle
  always_comb begin
    int p;
    logic [7:0] pins;
    p = selPort(c_reg.port);
    pins = lineIn[p*LINE_W +: LINE_W];
    s_next = s_reg;
    resWe = 1'b0;
    resData = BYTE_ZERO;
    s_next.fetch = results[fetchIndex];
    unique case (s_reg.st)
      // Ready falls only on a take, so an idle port keeps offering itself
      SDIO_IDLE: begin
        if (cmdValid && s_reg.ready) begin
          s_next.st = SDIO_EXEC;
          s_next.ready = 1'b0;
        end
      end
      // Execute the captured command, then offer again on the next cycle
      SDIO_EXEC: begin
        s_next.st = SDIO_IDLE;
        s_next.ready = 1'b1;
        unique case (c_reg.op)
          // Direction changes: one line or the whole byte
          SDIO_CFG_LINE: s_next.dir[p][c_reg.line] = c_reg.value[0];
          SDIO_CFG_PORT: s_next.dir[p] = c_reg.value;
          // Reads sample the pins in this cycle and store into the result slot
          SDIO_RD_PORT: begin
            resWe = 1'b1;
            resData = pins;
          end
          SDIO_RD_LINE: begin
            resWe = 1'b1;
            resData = {7'h00, pins[c_reg.line]};
          end
          SDIO_WR_LINE: s_next.out[p][c_reg.line] = c_reg.value[0];
          SDIO_WR_PORT: begin
            // Input lines keep their latch; undriven anyway.
            s_next.out[p] = (s_reg.out[p] & ~s_reg.dir[p]) | (c_reg.value & s_reg.dir[p]);
          end
          // The two spare op codes do nothing rather than corrupt state
          default: ;
        endcase
      end
    endcase
  end

  // State register and command capture
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_reg <= '{st: SDIO_IDLE, ready: 1'b1, dir: {PORTS{DIR_RESET}},
                 out: {PORTS{OUT_RESET}}, fetch: BYTE_ZERO};
      c_reg <= '0;
      idx_reg <= '0;
    end else if (clkEn) begin
      s_reg <= s_next;
      if (s_reg.st == SDIO_IDLE && cmdValid && s_reg.ready) begin
        c_reg <= cmd;
        idx_reg <= cmdIndex;
      end
    end
  end

  // Result store has no reset: contents are only valid once written
  always_ff @(posedge mclk) begin
    if (clkEn && resWe) results[idx_reg] <= resData;
  end

  assign cmdReady = s_reg.ready;
  assign fetchData = s_reg.fetch;
  assign lineOut = s_reg.out;
  assign lineOe = s_reg.dir;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_read_byte: assert property (clkEn && s_reg.st == SDIO_EXEC && c_reg.op == SDIO_RD_PORT
    |-> resData == lineIn[selPort(c_reg.port)*LINE_W +: LINE_W])
    else $error("port read byte wrong");
  a_line_high: assert property (clkEn && s_reg.st == SDIO_EXEC && c_reg.op == SDIO_WR_LINE
    && c_reg.value[0] |=> lineOut[selPort(c_reg.port)*LINE_W + c_reg.line])
    else $error("line not driven high");
  a_line_low: assert property (clkEn && s_reg.st == SDIO_EXEC && c_reg.op == SDIO_WR_LINE
    && !c_reg.value[0] |=> !lineOut[selPort(c_reg.port)*LINE_W + c_reg.line])
    else $error("line not driven low");
  a_line_only: assert property (clkEn && s_reg.st == SDIO_EXEC && c_reg.op == SDIO_WR_LINE
    |=> $countones(lineOut ^ $past(lineOut)) <= 1)
    else $error("other lines changed");
  a_inputs_kept: assert property (clkEn && s_reg.st == SDIO_EXEC && c_reg.op == SDIO_WR_PORT
    |=> ((lineOut ^ $past(lineOut)) & ~lineOe) == '0)
    else $error("input line changed");
  a_outputs_set: assert property (clkEn && s_reg.st == SDIO_EXEC && c_reg.op == SDIO_WR_PORT
    |=> (s_reg.out[selPort(c_reg.port)] & s_reg.dir[selPort(c_reg.port)])
        == (c_reg.value & s_reg.dir[selPort(c_reg.port)]))
    else $error("output lines not written");
  a_dir_cfg: assert property (clkEn && s_reg.st == SDIO_EXEC && c_reg.op == SDIO_CFG_PORT
    |=> s_reg.dir[selPort(c_reg.port)] == c_reg.value)
    else $error("direction byte not applied");
  a_bit_read: assert property (clkEn && s_reg.st == SDIO_EXEC && c_reg.op == SDIO_RD_LINE
    |-> resData[7:1] == 7'h00)
    else $error("line read not 0 or 1");
  a_in_order: assert property (clkEn && s_reg.st == SDIO_EXEC |-> !cmdReady)
    else $error("accepted while busy");
  a_stored: assert property (clkEn && resWe ##1 clkEn && fetchIndex == $past(idx_reg)
    ##1 1'b1 |-> fetchData == $past(resData, 2))
    else $error("result not stored");

  c_rd_port: cover property (s_reg.st == SDIO_EXEC && c_reg.op == SDIO_RD_PORT);
  c_wr_line: cover property (s_reg.st == SDIO_EXEC && c_reg.op == SDIO_WR_LINE);
  c_wr_port: cover property (s_reg.st == SDIO_EXEC && c_reg.op == SDIO_WR_PORT);
  c_rd_line: cover property (s_reg.st == SDIO_EXEC && c_reg.op == SDIO_RD_LINE);
  c_cfg_line: cover property (s_reg.st == SDIO_EXEC && c_reg.op == SDIO_CFG_LINE);

  // Handshake: a take leads to one execute cycle, then ready returns
  a_take_exec: assert property (clkEn && s_reg.st == SDIO_IDLE && cmdValid && cmdReady
    |=> s_reg.st == SDIO_EXEC)
    else $error("command not taken");
  a_ready_back: assert property (clkEn && s_reg.st == SDIO_EXEC |=> cmdReady)
    else $error("ready not restored");

  // Line configuration touches exactly the selected line's direction
  a_cfg_line: assert property (clkEn && s_reg.st == SDIO_EXEC && c_reg.op == SDIO_CFG_LINE
    |=> lineOe[selPort(c_reg.port)*LINE_W + c_reg.line] == c_reg.value[0])
    else $error("line direction not applied");

  // Directions and outputs only move on an execute cycle
  a_dir_quiet: assert property (clkEn && s_reg.st == SDIO_IDLE |=> $stable(lineOe))
    else $error("direction moved while idle");
  a_out_quiet: assert property (clkEn && s_reg.st == SDIO_IDLE |=> $stable(lineOut))
    else $error("output moved while idle");

  // A write to one port leaves the other port's latch alone
  a_other_port: assert property (clkEn && PORTS > 1 && s_reg.st == SDIO_EXEC
    && (c_reg.op == SDIO_WR_LINE || c_reg.op == SDIO_WR_PORT)
    |=> lineOut[(1 - selPort(c_reg.port))*LINE_W +: LINE_W]
        == $past(lineOut[(1 - selPort(c_reg.port))*LINE_W +: LINE_W]))
    else $error("other port written");

  // Line read carries the pin level in bit 0
  a_line_value: assert property (clkEn && s_reg.st == SDIO_EXEC && c_reg.op == SDIO_RD_LINE
    |-> resData[0] == lineIn[selPort(c_reg.port)*LINE_W + c_reg.line])
    else $error("line read level wrong");

  // The result store is written only while a read executes
  a_store_exec: assert property (resWe |-> s_reg.st == SDIO_EXEC)
    else $error("store written outside execute");
endmodule
`default_nettype wire

// [dv/sdio_pins.sv]
// Pin-side model of the outside circuitry on the general purpose lines.
// Assumes the port drives a line only while that line's enable is high.
`default_nettype none
module sdio_pins
  import sdio_pkg::*;
#(
  parameter int PORTS = PORT_N
) (
  input wire logic [PORTS*LINE_W-1:0] lineOut,
  input wire logic [PORTS*LINE_W-1:0] lineOe,
  input wire logic [PORTS*LINE_W-1:0] extDrive,
  output logic [PORTS*LINE_W-1:0] lineIn
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pin shows the port's level where it drives, else the outside level
  assign lineIn = (lineOe & lineOut) | (~lineOe & extDrive);
endmodule
`default_nettype wire

// [dv/tb.sv]
// Self-checking bench for the script-command line port, random commands.
// Assumes two ports and the two-cycle command spacing of the port.
`default_nettype none
module tb
  import sdio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst, cmdValid, cmdReady;
  sdio_cmd_s cmd;
  logic [IDX_W-1:0] cmdIndex, fetchIndex;
  logic [7:0] fetchData;
  logic [15:0] lineIn, lineOut, lineOe, extDrive;
  logic [7:0] dirM[2], outM[2], res[16];
  bit got[16];
  int num_errors = 0;
  int n_checks = 0;
  sdio_port #(.PORTS(2), .SCRIPT_DEPTH(16)) uut (.mclk(mclk), .rst(rst), .clkEn(1'b1),
    .cmdValid(cmdValid), .cmd(cmd), .cmdIndex(cmdIndex), .cmdReady(cmdReady),
    .fetchIndex(fetchIndex), .fetchData(fetchData), .lineIn(lineIn),
    .lineOut(lineOut), .lineOe(lineOe));
  sdio_pins #(.PORTS(2)) pins (.lineOut(lineOut), .lineOe(lineOe), .extDrive(extDrive),
    .lineIn(lineIn));
  // Clock at 50 MHz
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("Checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic fetch(logic [3:0] ix);
    @(posedge mclk);
    fetchIndex <= ix;
    repeat (3) @(posedge mclk);
    #1;
    chk("fetchData", {8'h00, fetchData}, {8'h00, res[ix]});
  endtask
  // One command: offer, hold until taken, then compare with the model
  task automatic run(sdio_op_e op, logic p, logic [2:0] ln, logic [7:0] v, logic [3:0] ix);
    int w;
    logic [7:0] pv;
    w = 0;
    @(posedge mclk);
    cmd <= '{op, p, ln, v};
    cmdIndex <= ix;
    cmdValid <= 1'b1;
    do begin
      @(posedge mclk);
      w++;
    end while (cmdReady !== 1'b1 && w < 20);
    cmdValid <= 1'b0;
    pv = (dirM[p] & outM[p]) | (~dirM[p] & extDrive[p*8+:8]);
    repeat (2) @(posedge mclk);
    #1;
    case (op)
      SDIO_CFG_LINE: dirM[p][ln] = v[0];
      SDIO_CFG_PORT: dirM[p] = v;
      SDIO_RD_LINE: res[ix] = {7'h00, pv[ln]};
      SDIO_RD_PORT: res[ix] = pv;
      SDIO_WR_LINE: outM[p][ln] = v[0];
      default: outM[p] = (outM[p] & ~dirM[p]) | (v & dirM[p]);
    endcase
    chk("lineOe", lineOe, {dirM[1], dirM[0]});
    chk("lineOut", lineOut & lineOe, {outM[1] & dirM[1], outM[0] & dirM[0]});
    if (op == SDIO_RD_LINE || op == SDIO_RD_PORT) begin
      got[ix] = 1'b1;
      fetch(ix);
    end
  endtask
  // Main sequence: reset, random script, then re-read every stored result
  initial begin
    rst = 1'b1;
    cmdValid = 1'b0;
    cmd = '0;
    cmdIndex = '0;
    fetchIndex = '0;
    extDrive = '0;
    dirM = '{default: 8'h00};
    outM = '{default: 8'h00};
    void'($urandom(32'hf2ae05a8));
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    #1;
    chk("resetOe", lineOe, 16'h0000);
    for (int i = 0; i < 120; i++) begin
      @(posedge mclk);
      extDrive <= 16'($urandom);
      // Two-port build, so either port number is legal here
      run(sdio_op_e'($urandom_range(5)), 1'($urandom), 3'($urandom), 8'($urandom), 4'(i));
    end
    // Results must survive later commands in their own slots
    for (int i = 0; i < 16; i++) if (got[i]) fetch(4'(i));
    report_and_stop;
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    report_and_stop;
  end
endmodule
`default_nettype wire
